/* File: logic/rx_skid_buffer.v */
// Purpose: two-entry buffer between receiver and reader
// Assumes: one clock, asynchronous low reset from the top
// Notes: holds two words; in_ready drops when both are full
`timescale 1ns/1ns
`include "serial_channel_n_regs.vh"
module rx_skid_buffer (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_flush,
	input wire i_in_valid,
	input wire [12:0] i_in_data,
	output wire o_in_ready,
	output wire o_out_valid,
	output wire [12:0] o_out_data,
	input wire i_out_ready
);
	reg [12:0] mem_r [0:1];
	reg wr_ptr_r;
	reg rd_ptr_r;
	reg [1:0] count_r;
	wire push;
	wire pop;
	assign o_in_ready = (count_r != 2'h2);
	assign o_out_valid = (count_r != 2'h0);
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem_r[rd_ptr_r];
	// Pointer and count upkeep
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
		end else if (i_flush) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			if (push)
				wr_ptr_r <= ~wr_ptr_r;
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end
	// Storage
	always @(posedge i_clk) begin
		if (push)
			mem_r[wr_ptr_r] <= i_in_data;
	end
endmodule // rx_skid_buffer

/* File: logic/serial_channel_n.v */
// Purpose: asynchronous serial channel with error flags and handshake
// Assumes: 50 MHz clock; CPU side as plain ports and strobes
// Notes: receive words pass a two-entry buffer before the buffer register
`timescale 1ns/1ns
`include "serial_channel_n_regs.vh"
// Behaviour
// - overrun sets, buffer overwritten, irq unchanged
// - mode invalid or rx disable clears overrun and framing errors
// - short stop bits flag framing error
// - error flags update at buffer transfer
// - parity mismatch sets parity error
// - reading low byte clears parity error
// - error sum is OR of three
// - rx enable toggle reinitialises receiver
// - in cts mode, transmit starts only while cts low
// - rts low ready, high on reception
// - handshake off, cts, or rts select
// - data logic select inverts data bits
// - polarity reverse inverts txd and rxd pins
// - collision compares tx and rx, raises irq
// - shift empty flag shows idle shifter
// - bit order only for 8-bit frames
// - unassigned control bit 3 reads as shift empty flag
// - start, data, parity, stop frame
// - bit rate is divider output over 16
module serial_channel_n (
	input wire i_clk,
	input wire i_arst_n,
	input wire [2:0] i_mode,
	input wire [1:0] i_clk_src,
	input wire [7:0] i_baud_divider,
	input wire i_ext_clk,
	input wire i_tx_enable,
	input wire i_rx_enable,
	input wire i_parity_enable,
	input wire i_parity_odd,
	input wire i_two_stop,
	input wire i_data_invert,
	input wire i_line_invert,
	input wire i_collision_detect,
	input wire [7:0] i_ctrl_wdata,
	input wire i_ctrl_we,
	input wire [8:0] i_tx_data,
	input wire i_tx_we,
	input wire i_rx_rd_lo,
	input wire i_rxd,
	input wire i_cts_rts_in,
	output reg [7:0] o_ctrl_rdata,
	output reg [8:0] o_rx_data,
	output reg o_rx_complete,
	output reg o_overrun,
	output reg o_framing_err,
	output reg o_parity_err,
	output reg o_error_sum,
	output reg o_tx_buf_empty,
	output reg o_tx_shift_empty_flag,
	output reg o_rx_irq,
	output reg o_tx_irq,
	output reg o_collision_irq,
	output reg o_txd,
	output reg o_txd_oe_n,
	output reg o_rts_cts_out,
	output reg o_rts_cts_oe_n
);
	reg [1:0] rst_sync_r;
	wire rst_n;
	reg [1:0] rxd_sync_r;
	reg [1:0] cts_sync_r;
	reg [1:0] ext_sync_r;
	reg [7:0] ctrl_r;
	reg [4:0] pre_r;
	reg [7:0] div_r;
	reg tick_r;
	reg ext_prev_r;
	wire src_pulse;
	reg rx_en_prev_r;
	wire err_clear;
	wire handshake_on;
	wire cts_mode;
	wire rts_mode;
	wire rxd_line;
	wire msb_first;
	// Decoded frame length in data bits
	function [3:0] frame_bits;
		input [2:0] mode;
		begin
			case (mode)
				`MODE_UART7: frame_bits = 4'h7;
				`MODE_UART9: frame_bits = 4'h9;
				default: frame_bits = 4'h8;
			endcase
		end
	endfunction
	// Even parity of a 9-bit word, masked to the frame length
	function par9;
		input [8:0] d;
		input [3:0] n;
		begin
			par9 = ^(d & ~(9'h1ff << n));
		end
	endfunction
	// Bit reversal within the low eight bits
	function [8:0] rev8;
		input [8:0] d;
		integer k;
		begin
			rev8 = d;
			for (k = 0; k < 8; k = k + 1)
				rev8[k] = d[7 - k];
		end
	endfunction
	// Reset release through two flip-flops
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];
	// Pin synchronisers
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_sync_r <= 2'h3;
			cts_sync_r <= 2'h3;
			ext_sync_r <= 2'h0;
		end else begin
			rxd_sync_r <= {rxd_sync_r[0], i_rxd};
			cts_sync_r <= {cts_sync_r[0], i_cts_rts_in};
			ext_sync_r <= {ext_sync_r[0], i_ext_clk};
		end
	end
	assign rxd_line = rxd_sync_r[1] ^ i_line_invert;
	// Handshake control byte; bit 3 unassigned and held at zero
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			ctrl_r <= `CTRL_RESET;
		else if (i_ctrl_we)
			ctrl_r <= i_ctrl_wdata & 8'hf7;
	end
	assign handshake_on = !ctrl_r[`CTRL_DISABLE_BIT];
	assign cts_mode = handshake_on && !ctrl_r[2];
	assign rts_mode = handshake_on && ctrl_r[2];
	assign msb_first = ctrl_r[7] && (i_mode == `MODE_UART8);
	// Count source select and baud divider
	assign src_pulse = (i_clk_src == `SRC_F1) ? 1'b1 :
		(i_clk_src == `SRC_F8) ? (pre_r[2:0] == 3'h7) :
		(i_clk_src == `SRC_F32) ? (pre_r == 5'h1f) :
		(ext_sync_r[1] && !ext_prev_r);
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_r <= 5'h0;
			div_r <= 8'h0;
			tick_r <= 1'b0;
			ext_prev_r <= 1'b0;
		end else begin
			pre_r <= pre_r + 5'h1;
			ext_prev_r <= ext_sync_r[1];
			tick_r <= 1'b0;
			if (src_pulse) begin
				if (div_r == 8'h0) begin
					div_r <= i_baud_divider;
					tick_r <= 1'b1;
				end else
					div_r <= div_r - 8'h1;
			end
		end
	end
	// Overrun and framing flags clear on invalid mode or receive disable
	assign err_clear = (i_mode == `MODE_INVALID) || !i_rx_enable;

	// ---------------- Transmitter ----------------
	localparam TX_IDLE = 2'h0;
	localparam TX_SHIFT = 2'h1;
	reg [1:0] tx_state_r;
	reg [8:0] tx_buf_r;
	reg [11:0] tx_sh_r;
	reg [3:0] tx_cnt_r;
	reg [3:0] tx_sub_r;
	reg tx_line_r;
	wire [3:0] tx_len;
	wire [8:0] tx_word;
	assign tx_len = 4'h2 + frame_bits(i_mode) + {3'h0, i_parity_enable} +
		{3'h0, i_two_stop};
	assign tx_word = msb_first ? rev8(tx_buf_r) : tx_buf_r;
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_r <= TX_IDLE;
			tx_buf_r <= 9'h0;
			tx_sh_r <= 12'hfff;
			tx_cnt_r <= 4'h0;
			tx_sub_r <= 4'h0;
			tx_line_r <= 1'b1;
			o_tx_buf_empty <= 1'b1;
			o_tx_shift_empty_flag <= 1'b1;
			o_tx_irq <= 1'b0;
		end else begin
			o_tx_irq <= 1'b0;
			if (i_mode == `MODE_INVALID)
				o_tx_buf_empty <= 1'b1;
			else if (i_tx_we && i_tx_enable) begin
				tx_buf_r <= i_tx_data ^ {9{i_data_invert}};
				o_tx_buf_empty <= 1'b0;
			end
			case (tx_state_r)
				TX_IDLE: begin
					tx_line_r <= 1'b1;
					if (!o_tx_buf_empty && i_tx_enable && tick_r &&
						(!cts_mode || !cts_sync_r[1])) begin
						// Start bit, data, parity, stop bits
						tx_sh_r <= ({3'h7, tx_word} |
							~(12'hfff >> (4'hc - frame_bits(i_mode)))) &
							~({11'h0, i_parity_enable} <<
							frame_bits(i_mode)) |
							({11'h0, i_parity_enable &
							(par9(tx_word, frame_bits(i_mode)) ^
							i_parity_odd)} << frame_bits(i_mode));
						tx_line_r <= 1'b0;
						tx_cnt_r <= tx_len - 4'h1;
						tx_sub_r <= 4'h0;
						o_tx_buf_empty <= 1'b1;
						o_tx_shift_empty_flag <= 1'b0;
						tx_state_r <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (tick_r) begin
						tx_sub_r <= tx_sub_r + 4'h1;
						if (tx_sub_r == 4'hf) begin
							if (tx_cnt_r == 4'h0) begin
								o_tx_shift_empty_flag <= 1'b1;
								o_tx_irq <= 1'b1;
								tx_state_r <= TX_IDLE;
							end else begin
								tx_line_r <= tx_sh_r[0];
								tx_sh_r <= {1'b1, tx_sh_r[11:1]};
								tx_cnt_r <= tx_cnt_r - 4'h1;
							end
						end
					end
				end
				default: tx_state_r <= TX_IDLE;
			endcase
		end
	end

	// ---------------- Receiver ----------------
	localparam RX_IDLE = 2'h0;
	localparam RX_BITS = 2'h1;
	reg [1:0] rx_state_r;
	reg [3:0] rx_sub_r;
	reg [3:0] rx_cnt_r;
	reg [10:0] rx_sh_r;
	reg rx_stop1_r;
	reg rx_push_r;
	reg [12:0] rx_word_r;
	wire [3:0] rx_len;
	wire [3:0] nb;
	wire [8:0] rx_data_raw;
	wire buf_in_ready;
	wire buf_valid;
	wire [12:0] buf_data;
	wire buf_take;
	assign nb = frame_bits(i_mode);
	assign rx_len = nb + {3'h0, i_parity_enable} + {3'h0, i_two_stop} + 4'h1;
	assign rx_data_raw = rx_sh_r[8:0] & ~(9'h1ff << nb);
	// Start edge, centre sampling and frame assembly
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_r <= RX_IDLE;
			rx_sub_r <= 4'h0;
			rx_cnt_r <= 4'h0;
			rx_sh_r <= 11'h0;
			rx_stop1_r <= 1'b1;
			rx_push_r <= 1'b0;
			rx_word_r <= 13'h0;
		end else begin
			rx_push_r <= rx_push_r && !buf_in_ready;
			if (!i_rx_enable || i_mode == `MODE_INVALID)
				rx_state_r <= RX_IDLE;
			else case (rx_state_r)
				RX_IDLE: begin
					if (tick_r && !rxd_line) begin
						rx_sub_r <= 4'h0;
						rx_cnt_r <= 4'h0;
						rx_state_r <= RX_BITS;
					end
				end
				RX_BITS: begin
					if (tick_r) begin
						rx_sub_r <= rx_sub_r + 4'h1;
						if (rx_sub_r == `SAMPLE_MID) begin
							rx_sub_r <= rx_sub_r + 4'h1;
							if (rx_cnt_r == 4'h0 && rxd_line)
								rx_state_r <= RX_IDLE; // False start
							else if (rx_cnt_r == rx_len) begin
								// Frame done: assemble word with flags
								rx_word_r <= {
									1'b0,
									!(rx_stop1_r && rxd_line),
									i_parity_enable &&
									(par9(rx_data_raw, nb) ^
									rx_sh_r[nb] ^ i_parity_odd),
									1'b0,
									msb_first ? rev8(rx_data_raw) :
									rx_data_raw};
								rx_push_r <= 1'b1;
								rx_state_r <= RX_IDLE;
							end else begin
								if (rx_cnt_r != 4'h0) begin
									if (rx_cnt_r ==
										nb + {3'h0, i_parity_enable} +
										4'h1)
										rx_stop1_r <= rxd_line;
									else
										rx_sh_r <= rx_sh_r |
											({10'h0, rxd_line} <<
											(rx_cnt_r - 4'h1));
								end else begin
									rx_sh_r <= 11'h0;
									rx_stop1_r <= 1'b1;
								end
								rx_cnt_r <= rx_cnt_r + 4'h1;
							end
						end
					end
				end
				default: rx_state_r <= RX_IDLE;
			endcase
		end
	end
	// Two-entry buffer between the receiver and the buffer register
	rx_skid_buffer u_rx_buf (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_flush(err_clear),
		.i_in_valid(rx_push_r),
		.i_in_data(rx_word_r),
		.o_in_ready(buf_in_ready),
		.o_out_valid(buf_valid),
		.o_out_data(buf_data),
		.i_out_ready(1'b1)
	);
	assign buf_take = buf_valid;
	// Buffer register, error flags and receive interrupt
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rx_data <= 9'h0;
			o_rx_complete <= 1'b0;
			o_overrun <= 1'b0;
			o_framing_err <= 1'b0;
			o_parity_err <= 1'b0;
			o_error_sum <= 1'b0;
			o_rx_irq <= 1'b0;
		end else begin
			o_rx_irq <= 1'b0;
			if (i_rx_rd_lo) begin
				o_rx_complete <= 1'b0;
				o_parity_err <= 1'b0;
			end
			if (err_clear) begin
				o_overrun <= 1'b0;
				o_framing_err <= 1'b0;
				o_rx_complete <= 1'b0;
			end
			if (buf_take && !err_clear) begin
				o_rx_data <= buf_data[8:0] ^ {9{i_data_invert}};
				o_rx_complete <= 1'b1;
				o_framing_err <= buf_data[11];
				o_parity_err <= buf_data[10];
				if (o_rx_complete && !i_rx_rd_lo)
					o_overrun <= 1'b1;
				else
					o_rx_irq <= 1'b1;
			end
			o_error_sum <= (o_overrun || o_framing_err || o_parity_err) &&
				!(err_clear && !o_parity_err);
		end
	end

	// ---------------- Pins, handshake, collision ----------------
	reg [3:0] coll_div_r;
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_txd <= 1'b1;
			o_txd_oe_n <= 1'b1;
			o_rts_cts_out <= 1'b1;
			o_rts_cts_oe_n <= 1'b1;
			o_collision_irq <= 1'b0;
			o_ctrl_rdata <= 8'h0;
			coll_div_r <= 4'h0;
		end else begin
			o_txd <= tx_line_r ^ i_line_invert;
			o_txd_oe_n <= (i_mode == `MODE_INVALID);
			o_rts_cts_oe_n <= !rts_mode;
			// Low while ready and idle; high once a start is seen
			o_rts_cts_out <= !(rts_mode && i_rx_enable &&
				rx_state_r == RX_IDLE && !o_rx_complete);
			o_ctrl_rdata <= {ctrl_r[7:4], 1'b0, ctrl_r[2],
				2'h0} | {4'h0, 1'b0, 1'b0, 1'b0,
				o_tx_shift_empty_flag} << 3;
			o_collision_irq <= 1'b0;
			if (tick_r)
				coll_div_r <= coll_div_r + 4'h1;
			// Rising transfer clock: compare output and input levels
			if (tick_r && coll_div_r == 4'h7 && i_collision_detect &&
				(tx_line_r != rxd_line))
				o_collision_irq <= 1'b1;
		end
	end
endmodule // serial_channel_n

/* File: logic/serial_channel_n_regs.vh */
// Purpose: constants for the asynchronous serial channel
// Assumes: 50 MHz system clock
// Notes: mode codes, field positions and reset values
`ifndef SERIAL_CHANNEL_N_REGS_VH
`define SERIAL_CHANNEL_N_REGS_VH
`define MODE_INVALID 3'h0
`define MODE_SYNC 3'h1
`define MODE_UART7 3'h4
`define MODE_UART8 3'h5
`define MODE_UART9 3'h6
`define SRC_F1 2'h0
`define SRC_F8 2'h1
`define SRC_F32 2'h2
`define SRC_EXT 2'h3
`define OVERSAMPLE 5'h10
`define SAMPLE_MID 4'h7
`define CTRL_DISABLE_BIT 4
`define CTRL_RESET 8'h10
`define BUF_DEPTH 2
`endif

/* File: sim/serial_channel_n_chk.sv */
// Purpose: port checker for the serial channel
// Assumes: one clock, asynchronous low reset
// Notes: bound to every instance of the channel
`timescale 1ns/1ns
`include "serial_channel_n_regs.vh"
module serial_channel_n_chk (
	input wire i_clk,
	input wire i_arst_n,
	input wire [2:0] i_mode,
	input wire i_rx_enable,
	input wire i_line_invert,
	input wire i_rx_rd_lo,
	input wire i_cts_rts_in,
	input wire [7:0] o_ctrl_rdata,
	input wire o_rx_complete,
	input wire o_overrun,
	input wire o_framing_err,
	input wire o_parity_err,
	input wire o_error_sum,
	input wire o_tx_shift_empty_flag,
	input wire o_rx_irq,
	input wire o_txd,
	input wire o_rts_cts_oe_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// Error summary and handshake mode decode
	wire any_err = o_overrun | o_framing_err | o_parity_err;
	wire cts_mode = !o_ctrl_rdata[`CTRL_DISABLE_BIT] && !o_ctrl_rdata[2];
	// Peer refusing while the shifter is idle
	sequence s_cts_refused;
		(cts_mode && i_cts_rts_in && o_tx_shift_empty_flag)[*6];
	endsequence
	chk_sum_sets: assert property (any_err && (o_parity_err ||
		i_rx_enable && i_mode != `MODE_INVALID) |=> o_error_sum)
		else $error("error sum not set");
	chk_sum_clears: assert property (!any_err |=> !o_error_sum)
		else $error("error sum not cleared");
	chk_read_clears_parity: assert property (i_rx_rd_lo |=> !o_parity_err)
		else $error("parity flag kept after read");
	chk_disable_clears: assert property ((!i_rx_enable ||
		i_mode == `MODE_INVALID) |=> !o_overrun && !o_framing_err)
		else $error("overrun or framing kept");
	chk_overrun_quiet: assert property ($rose(o_overrun) |->
		!o_rx_irq && !$past(o_rx_irq))
		else $error("receive irq on overrun");
	chk_flags_at_transfer: assert property ($rose(o_parity_err) ||
		$rose(o_framing_err) |-> o_rx_complete)
		else $error("flag rose without transfer");
	chk_idle_level: assert property ($past(o_tx_shift_empty_flag) &&
		o_tx_shift_empty_flag && $stable(i_line_invert)
		|-> o_txd == !i_line_invert)
		else $error("idle line level wrong");
	chk_handshake_off: assert property (o_ctrl_rdata[`CTRL_DISABLE_BIT]
		|-> o_rts_cts_oe_n)
		else $error("handshake pin driven while off");
	chk_cts_wait: assert property (s_cts_refused |=> o_tx_shift_empty_flag)
		else $error("transmit began while refused");
endmodule // serial_channel_n_chk
bind serial_channel_n serial_channel_n_chk i_serial_channel_n_chk (.*);

/* File: sim/serial_peer.sv */
// Purpose: far-side serial device model
// Assumes: bit time of BIT system clocks
// Notes: eight data bits, drives at falling edges
`timescale 1ns/1ns
module serial_peer #(parameter integer BIT = 16) (
	input wire i_clk,
	input wire i_txd,
	output reg o_rxd,
	output reg o_cts_n
);
	// Line idles high, peer ready to take data
	initial begin
		o_rxd = 1'b1;
		o_cts_n = 1'b0;
	end
	// Wait whole bit times
	task bits(input integer n);
		repeat (n * BIT) @(negedge i_clk);
	endtask
	// One frame out: start, data LSB first, parity, stop
	task send(input [7:0] d, input pen, input par, input stop);
		integer i;
		begin
			o_rxd = 1'b0;
			bits(1);
			for (i = 0; i < 8; i = i + 1) begin
				o_rxd = d[i];
				bits(1);
			end
			if (pen) begin
				o_rxd = par;
				bits(1);
			end
			o_rxd = stop;
			bits(1);
			o_rxd = 1'b1;
			bits(2);
		end
	endtask
	// One frame in, sampled at bit centres
	task recv(input pen, output [7:0] d, output p, output ok);
		integer i;
		begin
			ok = 1'b0;
			p = 1'b0;
			for (i = 0; i < 4000 && i_txd; i = i + 1)
				@(negedge i_clk);
			if (!i_txd) begin
				repeat (BIT / 2) @(negedge i_clk);
				for (i = 0; i < 8; i = i + 1) begin
					bits(1);
					d[i] = i_txd;
				end
				if (pen) begin
					bits(1);
					p = i_txd;
				end
				// Returns at the stop bit centre, before the frame ends
				bits(1);
				ok = i_txd;
			end
		end
	endtask
endmodule // serial_peer

/* File: sim/tb.sv */
// Purpose: self-checking bench for the serial channel
// Assumes: divider 0 on f1, so a bit is 16 clocks
// Notes: inputs change at falling edges
`timescale 1ns/1ns
`include "serial_channel_n_regs.vh"
module tb;
	reg i_clk = 1'b0;
	reg i_arst_n = 1'b0;
	reg [2:0] i_mode = `MODE_UART8;
	reg i_tx_enable = 1'b1;
	reg i_rx_enable = 1'b1;
	reg i_parity_enable = 1'b0;
	reg i_parity_odd = 1'b0;
	reg i_two_stop = 1'b0;
	reg i_data_invert = 1'b0;
	reg i_line_invert = 1'b0;
	reg [7:0] i_ctrl_wdata = `CTRL_RESET;
	reg i_ctrl_we = 1'b0;
	reg [8:0] i_tx_data = 9'h000;
	reg i_tx_we = 1'b0;
	reg i_rx_rd_lo = 1'b0;
	reg [7:0] rd;
	reg rp;
	reg ok;
	integer err_count = 0;
	integer total_checks = 0;
	wire rxd, cts_n, o_txd, o_rx_complete, o_overrun, o_framing_err;
	wire o_parity_err, o_error_sum, o_tx_shift_empty_flag;
	wire [8:0] o_rx_data;
	wire [7:0] o_ctrl_rdata;
	wire o_tx_buf_empty, o_rts_cts_out, o_rts_cts_oe_n;
	// Clock at 50 MHz
	always #10 i_clk = ~i_clk;
	serial_channel_n i_serial_channel_n (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_mode(i_mode), .i_clk_src(`SRC_F1), .i_baud_divider(8'h00),
		.i_ext_clk(1'b0), .i_tx_enable(i_tx_enable),
		.i_rx_enable(i_rx_enable), .i_parity_enable(i_parity_enable),
		.i_parity_odd(i_parity_odd), .i_two_stop(i_two_stop),
		.i_data_invert(i_data_invert), .i_line_invert(i_line_invert),
		.i_collision_detect(1'b0), .i_ctrl_wdata(i_ctrl_wdata),
		.i_ctrl_we(i_ctrl_we), .i_tx_data(i_tx_data), .i_tx_we(i_tx_we),
		.i_rx_rd_lo(i_rx_rd_lo), .i_rxd(rxd), .i_cts_rts_in(cts_n),
		.o_ctrl_rdata(o_ctrl_rdata), .o_rx_data(o_rx_data),
		.o_rx_complete(o_rx_complete), .o_overrun(o_overrun),
		.o_framing_err(o_framing_err), .o_parity_err(o_parity_err),
		.o_error_sum(o_error_sum), .o_tx_buf_empty(o_tx_buf_empty),
		.o_tx_shift_empty_flag(o_tx_shift_empty_flag), .o_rx_irq(),
		.o_tx_irq(), .o_collision_irq(), .o_txd(o_txd), .o_txd_oe_n(),
		.o_rts_cts_out(o_rts_cts_out), .o_rts_cts_oe_n(o_rts_cts_oe_n));
	serial_peer i_serial_peer (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(rxd),
		.o_cts_n(cts_n));
	// Compare and count
	task check(input string name, input [8:0] exp, input [8:0] got);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("FAIL %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	// One-cycle strobes on the CPU side
	task write_ctrl(input [7:0] v);
		begin
			i_ctrl_wdata = v;
			i_ctrl_we = 1'b1;
			@(negedge i_clk);
			i_ctrl_we = 1'b0;
		end
	endtask
	task write_tx(input [8:0] v);
		begin
			i_tx_data = v;
			i_tx_we = 1'b1;
			@(negedge i_clk);
			i_tx_we = 1'b0;
		end
	endtask
	task read_lo;
		begin
			i_rx_rd_lo = 1'b1;
			@(negedge i_clk);
			i_rx_rd_lo = 1'b0;
			@(negedge i_clk);
		end
	endtask
	// Wait for a received word, then compare data and flags
	task rx_check(input [7:0] d, input pe, input fe, input ov);
		integer n;
		begin
			for (n = 0; n < 100 && o_rx_complete !== 1'b1; n = n + 1)
				@(negedge i_clk);
			@(negedge i_clk);
			check("rx data", {1'b0, d}, {1'b0, o_rx_data[7:0]});
			check("parity", 9'(pe), 9'(o_parity_err));
			check("framing", 9'(fe), 9'(o_framing_err));
			check("overrun", 9'(ov), 9'(o_overrun));
			check("sum", 9'(pe | fe | ov), 9'(o_error_sum));
		end
	endtask
	// Transmit one word and compare what the peer saw
	task tx_check(input [8:0] v, input [7:0] exp);
		begin
			fork
				write_tx(v);
				i_serial_peer.recv(i_parity_enable, rd, rp, ok);
			join
			check("tx data", {1'b0, exp}, {1'b0, rd});
			check("tx stop", 9'h001, 9'(ok));
		end
	endtask
	// Report counts and give the verdict
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, err_count);
			if (err_count == 0 && total_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// Watchdog well past the expected run
	initial begin
		#400000;
		err_count = err_count + 1;
		$display("FAIL watchdog expected done seen timeout");
		finish_test;
	end
	// Test sequence
	initial begin
		repeat (10) @(negedge i_clk);
		i_arst_n = 1'b1;
		repeat (4) @(negedge i_clk);
		tx_check(9'h0a5, 8'ha5);
		check("shift busy", 9'h000, 9'(o_tx_shift_empty_flag));
		i_serial_peer.bits(2);
		check("shift idle", 9'h001, 9'(o_tx_shift_empty_flag));
		$display("test transmit done");
		i_parity_enable = 1'b1;
		i_serial_peer.send(8'h3c, 1'b1, ^8'h3c, 1'b1);
		rx_check(8'h3c, 1'b0, 1'b0, 1'b0);
		read_lo;
		i_serial_peer.send(8'h5a, 1'b1, ~^8'h5a, 1'b1);
		rx_check(8'h5a, 1'b1, 1'b0, 1'b0);
		read_lo;
		check("parity cleared", 9'h000, 9'(o_parity_err));
		check("sum cleared", 9'h000, 9'(o_error_sum));
		i_parity_odd = 1'b1;
		i_serial_peer.send(8'h81, 1'b1, ~^8'h81, 1'b1);
		rx_check(8'h81, 1'b0, 1'b0, 1'b0);
		read_lo;
		i_parity_enable = 1'b0;
		$display("test parity done");
		i_serial_peer.send(8'h77, 1'b0, 1'b0, 1'b0);
		rx_check(8'h77, 1'b0, 1'b1, 1'b0);
		read_lo;
		i_rx_enable = 1'b0;
		repeat (2) @(negedge i_clk);
		i_rx_enable = 1'b1;
		repeat (2) @(negedge i_clk);
		check("framing cleared", 9'h000, 9'(o_framing_err));
		i_two_stop = 1'b1;
		i_serial_peer.send(8'h12, 1'b0, 1'b0, 1'b1);
		rx_check(8'h12, 1'b0, 1'b0, 1'b0);
		read_lo;
		i_two_stop = 1'b0;
		$display("test framing done");
		i_serial_peer.send(8'h21, 1'b0, 1'b0, 1'b1);
		i_serial_peer.send(8'h42, 1'b0, 1'b0, 1'b1);
		rx_check(8'h42, 1'b0, 1'b0, 1'b1);
		i_mode = `MODE_INVALID;
		repeat (2) @(negedge i_clk);
		check("overrun cleared", 9'h000, 9'(o_overrun));
		i_mode = `MODE_UART8;
		read_lo;
		$display("test overrun done");
		i_data_invert = 1'b1;
		i_serial_peer.send(8'h0f, 1'b0, 1'b0, 1'b1);
		rx_check(8'hf0, 1'b0, 1'b0, 1'b0);
		read_lo;
		tx_check(9'h033, 8'hcc);
		i_data_invert = 1'b0;
		i_line_invert = 1'b1;
		repeat (4) @(negedge i_clk);
		check("inverted idle", 9'h000, 9'(o_txd));
		i_line_invert = 1'b0;
		repeat (4) @(negedge i_clk);
		$display("test inversion done");
		i_serial_peer.o_cts_n = 1'b1;
		write_ctrl(8'h00);
		write_tx(9'h066);
		repeat (64) @(negedge i_clk);
		check("cts hold", 9'h001, 9'(o_tx_shift_empty_flag));
		check("buf held", 9'h000, 9'(o_tx_buf_empty));
		check("cts pin input", 9'h001, 9'(o_rts_cts_oe_n));
		i_serial_peer.o_cts_n = 1'b0;
		i_serial_peer.recv(1'b0, rd, rp, ok);
		check("cts data", 9'h066, {1'b0, rd});
		i_serial_peer.bits(2);
		write_ctrl(8'h90);
		@(negedge i_clk);
		check("ctrl readback", 9'h098, {1'b0, o_ctrl_rdata});
		tx_check(9'h001, 8'h80);
		read_lo;
		write_ctrl(8'h04);
		@(negedge i_clk);
		check("rts ready", 9'h000, 9'(o_rts_cts_out));
		check("rts driven", 9'h000, 9'(o_rts_cts_oe_n));
		write_ctrl(`CTRL_RESET);
		$display("test handshake and order done");
		finish_test;
	end
endmodule // tb
